// >>> logic/mim_map.svh
// register offsets, field layout, vectors and widths of the interrupt mux
`ifndef MIM_MAP_SVH
`define MIM_MAP_SVH
`define MIM_ADDR_W 8
`define MIM_SRC_N 6
`define MIM_ENABLE_ADDR 8'h04
`define MIM_PENDING_ADDR 8'h04
`define MIM_EVT_STATUS_ADDR 8'h10
`define MIM_EVT_CLEAR_ADDR 8'h11
`define MIM_EVT_ENABLE_ADDR 8'h12
`define MIM_ENABLE_RST 8'h00
`define MIM_VEC_BASE 8'hF0
`define MIM_CAPTURE_BIT 3
`define MIM_OVERFLOW_BIT 4
`define MIM_EVT_ACK 0
`define MIM_EVT_BUSREQ 1
`define MIM_EVT_N 2
`endif

// >>> logic/mim_pkg.sv
// types shared by both ends of the interrupt mux
`default_nettype none
package mim_pkg;
   typedef logic [7:0] mim_byte_t;
   typedef logic [5:0] mim_src_t;
endpackage
`default_nettype wire

// >>> logic/mim_if.sv
// link between the interrupt mux and the processor bus end
`timescale 1ns/1ps
`default_nettype none
interface mim_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] rdata;
   logic rdata_oe;
   logic opcode_fetch_cycle;
   logic io_request_strobe;
   logic combined_irq_request_n;
   logic option_bus_request_n;
   logic nmi_n;
   logic [7:0] vector;
   logic vector_oe;
   logic bus_float;
   modport dev
   (
      input addr, wdata, io_wr, io_rd, opcode_fetch_cycle, io_request_strobe,
      output rdata, rdata_oe, combined_irq_request_n, option_bus_request_n, nmi_n,
      output vector, vector_oe,
      input bus_float
   );
   modport cpu
   (
      output addr, wdata, io_wr, io_rd, opcode_fetch_cycle, io_request_strobe,
      input rdata, rdata_oe, combined_irq_request_n, option_bus_request_n, nmi_n,
      input vector, vector_oe,
      output bus_float
   );
endinterface
`default_nettype wire

// >>> logic/mim_prio_enc.sv
// fixed-priority encoder: lowest numbered set bit wins
`timescale 1ns/1ps
`default_nettype none
`include "mim_map.svh"
module mim_prio_enc
   import mim_pkg::*;
#(
   parameter int N = `MIM_SRC_N
)
(
   input wire logic [N-1:0] i_req,
   output logic o_any,
   output logic [2:0] o_index
);
   // ***************************************************
   // priority search
   // ***************************************************
   // scan from the top bit down; the last hit, the lowest bit, wins
   always_comb
   begin
      o_any = 1'b0;
      o_index = 3'h0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any = 1'b1;
            o_index = 3'(k);
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/mim_device.sv
// interrupt mux device end: enables, pending flags, vector supply
`timescale 1ns/1ps
`default_nettype none
`include "mim_map.svh"
module mim_device
   import mim_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   mim_if.dev bus,
   input wire logic i_alarm_src,
   input wire logic i_serial_rx_src,
   input wire logic i_carrier_src,
   input wire logic i_capture_event,
   input wire logic i_overflow_event,
   input wire logic i_option_src,
   input wire logic i_option_bus_req_n,
   output logic o_enable_view,
   output logic o_irq
);
   // enable bits, internal flags and the gathered sources
   mim_byte_t enable_reg;
   mim_src_t capture_overflow_reg;
   mim_src_t pending;
   mim_src_t active;
   // vector supply and register read path
   mim_byte_t vector_reg;
   mim_byte_t rdata_reg;
   logic rdata_oe_reg;
   // event status, enables and set pulses
   logic [`MIM_EVT_N-1:0] evt_status_reg;
   logic [`MIM_EVT_N-1:0] evt_enable_reg;
   logic [`MIM_EVT_N-1:0] evt_set;
   // acknowledge tracking and priority result
   logic ack_cycle;
   logic ack_cycle_d_reg;
   logic bus_req_d_reg;
   logic any_active;
   logic [2:0] win_index;
   logic cap_clear;
   logic ovf_clear;
   // ***************************************************
   // enable register
   // ***************************************************
   // bits 7 and 6 are kept at zero
   // write-only; a read at this offset returns the pending view
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         enable_reg <= `MIM_ENABLE_RST;
      else if (bus.io_wr && bus.addr == `MIM_ENABLE_ADDR)
         enable_reg <= {2'b00, bus.wdata[5:0]};
   end
   // ***************************************************
   // internal capture and overflow flags
   // ***************************************************
   // an acknowledge is an opcode fetch with the I/O strobe up
   assign ack_cycle = bus.opcode_fetch_cycle && bus.io_request_strobe;
   // an acknowledge served for the flag clears it; a new event wins
   assign cap_clear = ack_cycle && !ack_cycle_d_reg && any_active
      && win_index == 3'(`MIM_CAPTURE_BIT);
   assign ovf_clear = ack_cycle && !ack_cycle_d_reg && any_active
      && win_index == 3'(`MIM_OVERFLOW_BIT);
   // flags 3 and 4 are sticky: a one-cycle event pulse holds the
   // request until the acknowledge that serves it; other bits stay zero
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         capture_overflow_reg <= 6'h00;
      else
      begin
         capture_overflow_reg[`MIM_CAPTURE_BIT] <= i_capture_event
            || (capture_overflow_reg[`MIM_CAPTURE_BIT] && !cap_clear);
         capture_overflow_reg[`MIM_OVERFLOW_BIT] <= i_overflow_event
            || (capture_overflow_reg[`MIM_OVERFLOW_BIT] && !ovf_clear);
      end
   end
   // ***************************************************
   // source gathering and priority
   // ***************************************************
   // order: alarm, serial, carrier, capture, overflow, option
   assign pending = {i_option_src, capture_overflow_reg[`MIM_OVERFLOW_BIT],
      capture_overflow_reg[`MIM_CAPTURE_BIT], i_carrier_src, i_serial_rx_src,
      i_alarm_src};
   // the masked view feeds both the request line and the vector
   assign active = pending & enable_reg[5:0];
   // the encoder sees only enabled sources, so a masked one never wins
   mim_prio_enc #(.N(`MIM_SRC_N)) u_prio
   (
      .i_req(active),
      .o_any(any_active),
      .o_index(win_index)
   );
   // ***************************************************
   // processor request lines
   // ***************************************************
   // request stays low while any enabled source is still pending
   assign bus.combined_irq_request_n = !any_active;
   // the option unit's bus request passes through untouched
   assign bus.option_bus_request_n = i_option_bus_req_n;
   // the non-maskable input is never used
   assign bus.nmi_n = 1'b1;
   // ***************************************************
   // vector supply during acknowledge
   // ***************************************************
   // vector frozen at the start of the acknowledge so it stays stable to T3
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         vector_reg <= `MIM_VEC_BASE;
         ack_cycle_d_reg <= 1'b0;
      end
      else
      begin
         ack_cycle_d_reg <= ack_cycle;
         if (ack_cycle && !ack_cycle_d_reg)
            vector_reg <= `MIM_VEC_BASE | {4'h0, win_index, 1'b0};
      end
   end
   // offered from the first wait state to the end of T3; a source that
   // drops mid-acknowledge cannot change the byte already frozen
   assign bus.vector = vector_reg;
   assign bus.vector_oe = ack_cycle && ack_cycle_d_reg;
   // ***************************************************
   // register reads
   // ***************************************************
   // read data is registered and stands until the next read
   // unmapped offsets and the write-only clear read back as zero
   // the output enable marks only the cycle after the read strobe
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_reg <= 8'h00;
         rdata_oe_reg <= 1'b0;
      end
      else
      begin
         rdata_oe_reg <= bus.io_rd;
         if (bus.io_rd)
         begin
            unique case (bus.addr)
               `MIM_PENDING_ADDR: rdata_reg <= {2'b00, pending};
               `MIM_EVT_STATUS_ADDR: rdata_reg <= {6'h00, evt_status_reg};
               `MIM_EVT_ENABLE_ADDR: rdata_reg <= {6'h00, evt_enable_reg};
               default: rdata_reg <= 8'h00;
            endcase
         end
      end
   end
   assign bus.rdata = rdata_reg;
   assign bus.rdata_oe = rdata_oe_reg;
   // ***************************************************
   // event interrupt block
   // ***************************************************
   // delayed bus request resets to the idle high level: no false edge
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         bus_req_d_reg <= 1'b1;
      else
         bus_req_d_reg <= i_option_bus_req_n;
   end
   // events: start of an acknowledge, falling edge of the bus request
   assign evt_set[`MIM_EVT_ACK] = ack_cycle && !ack_cycle_d_reg;
   assign evt_set[`MIM_EVT_BUSREQ] = bus_req_d_reg && !i_option_bus_req_n;
   // set wins over a clear in the same cycle
   // a write to the clear offset drops the bits written as one
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         evt_status_reg <= '0;
      else if (bus.io_wr && bus.addr == `MIM_EVT_CLEAR_ADDR)
         evt_status_reg <= (evt_status_reg & ~bus.wdata[`MIM_EVT_N-1:0]) | evt_set;
      else
         evt_status_reg <= evt_status_reg | evt_set;
   end
   // event enables are read-write
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         evt_enable_reg <= '0;
      else if (bus.io_wr && bus.addr == `MIM_EVT_ENABLE_ADDR)
         evt_enable_reg <= bus.wdata[`MIM_EVT_N-1:0];
   end
   // level interrupt while an enabled event is held
   assign o_irq = |(evt_status_reg & evt_enable_reg);
   // summary of the source enables for the outside
   assign o_enable_view = |enable_reg[5:0];
endmodule
`default_nettype wire

// >>> logic/mim_cpu.sv
// processor bus end: register port, request sampling, acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
`include "mim_map.svh"
module mim_cpu
   import mim_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   mim_if.cpu bus,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_instr_last,
   input wire logic i_int_enable,
   output logic o_ack_busy,
   output logic o_vector_valid,
   output logic [7:0] o_vector,
   output logic o_bus_floated
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_TW1 = 3'b011,
      ST_TW2 = 3'b100,
      ST_T3 = 3'b101
   } mim_ack_t;
   mim_ack_t state_reg;
   mim_byte_t vector_reg;
   logic valid_reg;
   logic float_reg;
   // ***************************************************
   // register port passes through; read and write strobes are held off during an acknowledge or bus release
   // ***************************************************
   assign bus.addr = i_addr;
   assign bus.wdata = i_wdata;
   assign bus.io_wr = i_wr && state_reg == ST_IDLE && !float_reg;
   assign bus.io_rd = i_rd && state_reg == ST_IDLE && !float_reg;
   assign o_rdata = bus.rdata;
   // ***************************************************
   // acknowledge sequence
   // ***************************************************
   // request sampled only at the last state of an instruction
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_reg <= ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
               if (i_instr_last && i_int_enable && !bus.combined_irq_request_n
                  && bus.option_bus_request_n)
                  state_reg <= ST_T1;
            ST_T1: state_reg <= ST_T2;
            ST_T2: state_reg <= ST_TW1;
            ST_TW1: state_reg <= ST_TW2;
            ST_TW2: state_reg <= ST_T3;
            ST_T3: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   assign bus.opcode_fetch_cycle = state_reg != ST_IDLE;
   assign bus.io_request_strobe = state_reg != ST_IDLE && state_reg != ST_T1;
   // vector latched at the rising edge that ends T3 state
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         vector_reg <= 8'h00;
         valid_reg <= 1'b0;
      end
      else
      begin
         valid_reg <= state_reg == ST_T3;
         if (state_reg == ST_T3 && bus.vector_oe)
            vector_reg <= bus.vector;
      end
   end
   // ***************************************************
   // bus release for option unit
   // ***************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         float_reg <= 1'b0;
      else if (bus.option_bus_request_n)
         float_reg <= 1'b0;
      else if (i_instr_last && state_reg == ST_IDLE)
         float_reg <= 1'b1;
   end
   assign bus.bus_float = float_reg;
   assign o_vector = vector_reg;
   assign o_vector_valid = valid_reg;
   assign o_ack_busy = state_reg != ST_IDLE;
   assign o_bus_floated = float_reg;
endmodule
`default_nettype wire

// >>> tb/mim_properties.sv
// checker watching the link between the interrupt mux and the processor end
`timescale 1ns/1ps
`default_nettype none
`include "mim_map.svh"
module mim_properties
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe,
   input wire logic opcode_fetch_cycle,
   input wire logic io_request_strobe,
   input wire logic combined_irq_request_n,
   input wire logic nmi_n,
   input wire logic [7:0] vector,
   input wire logic vector_oe
);
   logic [5:0] en_reg;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // shadow of the enable bits, so vectors can be tied to what was enabled
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         en_reg <= 6'h00;
      else if (io_wr && addr == `MIM_ENABLE_ADDR)
         en_reg <= wdata[5:0];
   end
   // ****************
   // link properties
   // ****************
   property p_nmi_idle; nmi_n; endproperty
   property p_rd_answer; io_rd |=> rdata_oe; endproperty
   property p_masked; (en_reg == 6'h00) |-> combined_irq_request_n; endproperty
   property p_vec_range; vector_oe |-> (vector[7:4] == 4'hF && !vector[0] && vector[3:0] <= 4'hA);
   endproperty
   property p_vec_enabled; vector_oe |-> en_reg[vector[3:1]]; endproperty
   property p_vec_stable; (vector_oe && $past(vector_oe)) |-> $stable(vector); endproperty
   property p_vec_t3; $fell(opcode_fetch_cycle) |-> $past(vector_oe); endproperty
   property p_vec_window; $rose(io_request_strobe) |=> vector_oe [*3]; endproperty
   property p_unused_bits; (io_rd && addr == `MIM_PENDING_ADDR) |=> (rdata[7:6] == 2'b00);
   endproperty
   property p_pend_req; (io_rd && addr == `MIM_PENDING_ADDR)
      |=> ((|(rdata[5:0] & en_reg)) == !$past(combined_irq_request_n)); endproperty
   a_nmi_idle: assert property (p_nmi_idle) else $error("nmi line driven");
   a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
   a_masked: assert property (p_masked) else $error("request with no enable");
   a_vec_range: assert property (p_vec_range) else $error("bad vector");
   a_vec_enabled: assert property (p_vec_enabled) else $error("masked vector");
   a_vec_stable: assert property (p_vec_stable) else $error("vector moved");
   a_vec_t3: assert property (p_vec_t3) else $error("no vector at T3");
   a_vec_window: assert property (p_vec_window) else $error("vector window short");
   a_unused_bits: assert property (p_unused_bits) else $error("bits 7:6 set");
   a_pend_req: assert property (p_pend_req) else $error("request vs pending");
   c_request: cover property (!combined_irq_request_n);
   c_last_vec: cover property (vector_oe && vector == 8'hFA);
   c_read: cover property (rdata_oe && rdata != 8'h00);
endmodule
`default_nettype wire

// >>> tb/main_cpu_interrupt_mux_tb.sv
// self-checking bench joining both ends of the interrupt mux
`timescale 1ns/1ps
`default_nettype none
module main_cpu_interrupt_mux_tb;
   import mim_pkg::*;
   logic i_clock, i_rst_n, wr, rd, last, ie, bus_req_n, busy, vec_valid, floated, view, irq;
   mim_byte_t addr, wdata, rdata, vec;
   logic [5:0] src;
   integer mismatches = 0;
   integer n_compared = 0;
   mim_if u_mim_if();
   mim_device u_mim_device(.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(u_mim_if),
      .i_alarm_src(src[0]), .i_serial_rx_src(src[1]), .i_carrier_src(src[2]),
      .i_capture_event(src[3]), .i_overflow_event(src[4]), .i_option_src(src[5]),
      .i_option_bus_req_n(bus_req_n), .o_enable_view(view), .o_irq(irq));
   mim_cpu u_mim_cpu(.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(u_mim_if), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_instr_last(last),
      .i_int_enable(ie), .o_ack_busy(busy), .o_vector_valid(vec_valid), .o_vector(vec),
      .o_bus_floated(floated));
   mim_properties u_mim_properties(.i_clock(i_clock), .i_rst_n(i_rst_n),
      .addr(u_mim_if.addr), .wdata(u_mim_if.wdata), .io_wr(u_mim_if.io_wr),
      .io_rd(u_mim_if.io_rd), .rdata(u_mim_if.rdata), .rdata_oe(u_mim_if.rdata_oe),
      .opcode_fetch_cycle(u_mim_if.opcode_fetch_cycle),
      .io_request_strobe(u_mim_if.io_request_strobe),
      .combined_irq_request_n(u_mim_if.combined_irq_request_n), .nmi_n(u_mim_if.nmi_n),
      .vector(u_mim_if.vector), .vector_oe(u_mim_if.vector_oe));
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge i_clock) wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock) {rd, addr} <= {1'b1, a};
      @(posedge i_clock) rd <= 1'b0;
      #10;
      check(rdata, exp);
   endtask
   // one acknowledge cycle, waiting a bounded time for the vector
   task automatic ack(input logic [7:0] exp);
      @(posedge i_clock) last <= 1'b1;
      @(posedge i_clock) last <= 1'b0;
      for (int n = 0; n < 20; n++)
      begin
         #1;
         if (vec_valid === 1'b1)
            break;
         @(posedge i_clock);
      end
      check({7'h00, vec_valid}, 8'h01);
      check(vec, exp);
   endtask
   // clock of 100 ns period
   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   // watchdog
   initial
   begin
      #300000;
      mismatches++;
      test_done();
   end
   // main sequence
   initial
   begin
      {i_rst_n, wr, rd, last, addr, wdata, src} = '0;
      {ie, bus_req_n} = 2'b11;
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rd_reg(8'h04, 8'h00);
      check({7'h00, u_mim_if.nmi_n}, 8'h01);
      @(posedge i_clock) src <= 6'h3F;
      @(posedge i_clock) src <= 6'h27;
      rd_reg(8'h04, 8'h3F);
      check({7'h00, u_mim_if.combined_irq_request_n}, 8'h01);
      wr_reg(8'h04, 8'hFF);
      check({7'h00, view}, 8'h01);
      check({7'h00, u_mim_if.combined_irq_request_n}, 8'h00);
      for (int n = 0; n < 6; n++)
      begin
         wr_reg(8'h04, 8'(8'hFF << n));
         ack(8'(8'hF0 + 2 * n));
      end
      rd_reg(8'h04, 8'h27);
      rd_reg(8'h10, 8'h01);
      wr_reg(8'h12, 8'h01);
      rd_reg(8'h10, 8'h01);
      check({7'h00, irq}, 8'h01);
      wr_reg(8'h12, 8'h00);
      rd_reg(8'h12, 8'h00);
      check({7'h00, irq}, 8'h00);
      wr_reg(8'h11, 8'h01);
      wr_reg(8'h12, 8'h01);
      rd_reg(8'h10, 8'h00);
      check({7'h00, irq}, 8'h00);
      rd_reg(8'h20, 8'h00);
      // no acknowledge while the processor has interrupts disabled
      @(posedge i_clock) {ie, last} <= 2'b01;
      @(posedge i_clock) {ie, last} <= 2'b10;
      #1;
      check({7'h00, busy}, 8'h00);
      @(posedge i_clock) bus_req_n <= 1'b0;
      #1;
      check({7'h00, u_mim_if.option_bus_request_n}, 8'h00);
      @(posedge i_clock) last <= 1'b1;
      @(posedge i_clock) last <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      check({6'h00, floated, busy}, 8'h02);
      @(posedge i_clock) bus_req_n <= 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      check({7'h00, floated}, 8'h00);
      rd_reg(8'h10, 8'h02);
      wr_reg(8'h04, 8'h00);
      check({7'h00, u_mim_if.combined_irq_request_n}, 8'h01);
      test_done();
   end
endmodule
`default_nettype wire
